//--- hdl/sdma_core.sv
// Data memory addressing for an 8-bit core: two sectors, pointers,
// indirect ports, accumulator, counter low byte and table registers.
// Assumes all inputs come from core logic on i_clk; strobes are one
// cycle long and never two at once.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "sdma_defs.svh"

module sdma_core #(
  parameter int RAM_WORDS = 128
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [8:0] i_addr,
  input  wire logic       i_ext,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_bit_set,
  input  wire logic       i_bit_clr,
  input  wire logic [2:0] i_bit_sel,
  input  wire logic       i_wr_from_acc,
  input  wire logic       i_rd_to_acc,
  input  wire logic       i_alu_valid,
  input  wire logic [7:0] i_alu_result,
  input  wire logic       i_pc_load,
  input  wire logic [7:0] i_pc_low,
  input  wire logic       i_tbl_done,
  input  wire logic [7:0] i_tbl_high,
  output logic      [7:0] o_rdata,
  output logic      [7:0] o_acc,
  output logic      [7:0] o_pc_low,
  output logic            o_pc_jump,
  output logic            o_dummy_cycle,
  output logic     [15:0] o_table_addr,
  output logic      [7:0] o_table_high
);
  import sdma_pkg::*;

  sdma_state_type q;
  sdma_state_type next_q;

  // Sector count; each sector has its own general-purpose RAM
  localparam int SECTORS = 2;

  // Read port of each sector's RAM
  logic [7:0] sec_rd [0:SECTORS-1];

  logic       sec;
  logic [7:0] lo;
  logic       via_port;
  logic       nested;
  logic       is_port;
  logic [7:0] cur;
  logic [7:0] src;
  logic [7:0] mask;
  logic [7:0] wval;
  logic       we;
  logic       ram_we;

  // Reads one special location of sector 0
  function automatic logic [7:0] sfr_read(
    input logic [7:0]     a,
    input sdma_state_type s
  );
    logic [7:0] v;
    v = `SDMA_RST_BYTE;
    unique case (a)
      `SDMA_A_PTR0:   v = s.ptr0;
      `SDMA_A_PTR1L:  v = s.ptr1_lo;
      `SDMA_A_PTR1S:  v = s.ptr1_sec;
      `SDMA_A_PTR2L:  v = s.ptr2_lo;
      `SDMA_A_PTR2S:  v = s.ptr2_sec;
      `SDMA_A_ACC:    v = s.acc;
      `SDMA_A_PCLOW:  v = s.pc_low;
      `SDMA_A_TBLLO:  v = s.tbl_lo;
      `SDMA_A_TBLHI:  v = s.tbl_hi;
      `SDMA_A_TBLHB:  v = s.tbl_hbyte;
      `SDMA_A_LASTEA: v = s.last_ea[7:0];
      default:        v = `SDMA_RST_BYTE; // Unused reads zero
    endcase
    return v;
  endfunction

  // Tells whether a sector-0 offset is one of the indirect ports
  function automatic logic port_addr(input logic [7:0] a);
    return (a == `SDMA_A_PORT0) || (a == `SDMA_A_PORT1) ||
           (a == `SDMA_A_PORT2);
  endfunction

  // Address resolution: direct, extended or through a pointer
  always_comb begin
    // Standard form sees sector 0, extended form all sectors
    sec      = i_ext ? i_addr[`SDMA_SEC_BIT] : 1'b0;
    lo       = i_addr[7:0];
    via_port = 1'b0;
    is_port  = !sec && port_addr(lo);
    if (is_port) begin
      via_port = 1'b1;
      // Ports hold no storage; the pointer names the location
      unique case (lo)
        `SDMA_A_PORT0: begin
          sec = 1'b0;
          lo  = q.ptr0;
        end
        `SDMA_A_PORT1: begin
          sec = q.ptr1_sec[0];
          lo  = q.ptr1_lo;
        end
        default: begin
          sec = q.ptr2_sec[0];
          lo  = q.ptr2_lo;
        end
      endcase
    end
    // A pointer aimed back at a port reaches nothing
    nested = via_port && !sec && port_addr(lo);
  end

  // Current value of the resolved location
  always_comb begin
    if (nested) begin
      cur = `SDMA_RST_BYTE;
    end else if (lo[`SDMA_RAM_BIT]) begin
      cur = sec_rd[sec];
    end else if (sec) begin
      cur = `SDMA_RST_BYTE;
    end else begin
      cur = sfr_read(lo, q);
    end
  end

  // Write value: bus data or accumulator, whole byte or one bit
  always_comb begin
    src  = i_wr_from_acc ? q.acc : i_wdata;
    mask = 8'h01 << i_bit_sel;
    if (i_bit_set) begin
      wval = cur | mask;
    end else if (i_bit_clr) begin
      wval = cur & ~mask;
    end else begin
      wval = src;
    end
    we     = (i_wr || i_bit_set || i_bit_clr) && !nested;
    ram_we = we && lo[`SDMA_RAM_BIT];
  end

  // Next state of the register set
  always_comb begin
    next_q       = q;
    next_q.jump  = 1'b0;
    next_q.dummy = 1'b0;

    // Read data stand for exactly one cycle
    next_q.rdata = i_rd ? cur : `SDMA_RST_BYTE;

    // Core-side updates, overridden by a bus write below
    if (i_alu_valid) begin
      next_q.acc = i_alu_result;
    end
    if (i_rd && i_rd_to_acc) begin
      next_q.acc = cur;
    end
    if (i_pc_load) begin
      next_q.pc_low = i_pc_low;
    end
    if (i_tbl_done) begin
      next_q.tbl_hbyte = i_tbl_high;
    end

    // Track the effective address of every access
    if (i_rd || i_wr || i_bit_set || i_bit_clr) begin
      next_q.last_ea = {sec, lo};
    end

    // Special-space writes; 8-bit stores wrap, no carry
    if (we && !lo[`SDMA_RAM_BIT] && !sec) begin
      unique case (lo)
        `SDMA_A_PTR0:  next_q.ptr0     = wval;
        `SDMA_A_PTR1L: next_q.ptr1_lo  = wval;
        `SDMA_A_PTR1S: next_q.ptr1_sec = wval;
        `SDMA_A_PTR2L: next_q.ptr2_lo  = wval;
        `SDMA_A_PTR2S: next_q.ptr2_sec = wval;
        `SDMA_A_ACC:   next_q.acc      = wval;
        `SDMA_A_TBLLO: next_q.tbl_lo   = wval;
        `SDMA_A_TBLHI: next_q.tbl_hi   = wval;
        `SDMA_A_TBLHB: next_q.tbl_hbyte = wval;
        `SDMA_A_PCLOW: begin
          // Jump inside the current page only
          next_q.pc_low = wval;
          next_q.jump   = 1'b1;
          next_q.dummy  = 1'b1;
        end
        // Last-address register is read-only
        default: next_q = next_q;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q.ptr0      <= `SDMA_RST_BYTE;
      q.ptr1_lo   <= `SDMA_RST_BYTE;
      q.ptr1_sec  <= `SDMA_RST_BYTE;
      q.ptr2_lo   <= `SDMA_RST_BYTE;
      q.ptr2_sec  <= `SDMA_RST_BYTE;
      q.acc       <= `SDMA_RST_BYTE;
      q.pc_low    <= `SDMA_RST_BYTE;
      q.tbl_lo    <= `SDMA_RST_BYTE;
      q.tbl_hi    <= `SDMA_RST_BYTE;
      q.tbl_hbyte <= `SDMA_RST_BYTE;
      q.last_ea   <= `SDMA_RST_EA;
      q.rdata     <= `SDMA_RST_BYTE;
      q.jump      <= 1'b0;
      q.dummy     <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // One RAM per sector, 8 bits per location
  for (genvar s = 0; s < SECTORS; s++) begin : g_sector
    logic [7:0] mem [0:RAM_WORDS-1];
    logic       here_we;

    // Only the selected sector takes the write
    assign here_we   = ram_we && (sec == 1'(s));
    assign sec_rd[s] = mem[lo[6:0]];

    always_ff @(posedge i_clk) begin
      if (here_we) begin
        mem[lo[6:0]] <= wval;
      end
    end
  end

  // Outputs straight from the state register
  assign o_rdata       = q.rdata;
  assign o_acc         = q.acc;
  assign o_pc_low      = q.pc_low;
  assign o_pc_jump     = q.jump;
  assign o_dummy_cycle = q.dummy;
  assign o_table_addr  = {q.tbl_hi, q.tbl_lo};
  assign o_table_high  = q.tbl_hbyte;

endmodule

`default_nettype wire

//--- inc/sdma_defs.svh
// Constants of the sectored data memory addressing block.
// Assumes one core clock; included by the package and the design.
// How it works
// - Two sectors of 8-bit storage.
// - Low half special space, high half RAM.
// - Unused special locations read as zero.
// - Read-only special locations ignore writes.
// - Sector byte plus low byte, no bank register.
// - Extended access carries 9-bit address.
// - Standard access names sector 0 only; ports 1 and 2 reach any sector.
// - Indirect ports act on pointed location.
// - Port zero sector 0; others any sector.
// - Port through port reads zero, writes nothing.
// - Five pointer bytes are ordinary registers.
// - Counter low write jumps, adds dummy cycle.
// - Table pointers address; high byte latched.
// - RAM bits can be set and cleared.
// - Accumulator holds results; moves pass through.
`ifndef SDMA_DEFS_SVH
`define SDMA_DEFS_SVH

// Special-space offsets in sector 0
`define SDMA_A_PORT0   8'h00
`define SDMA_A_PTR0    8'h01
`define SDMA_A_PORT1   8'h02
`define SDMA_A_PTR1L   8'h03
`define SDMA_A_PTR1S   8'h04
`define SDMA_A_ACC     8'h05
`define SDMA_A_PCLOW   8'h06
`define SDMA_A_TBLLO   8'h07
`define SDMA_A_TBLHB   8'h08
`define SDMA_A_TBLHI   8'h09
`define SDMA_A_PORT2   8'h0a
`define SDMA_A_PTR2L   8'h0b
`define SDMA_A_PTR2S   8'h0c
`define SDMA_A_LASTEA  8'h0d

// Field positions
`define SDMA_RAM_BIT   7
`define SDMA_SEC_BIT   8

// Reset values
`define SDMA_RST_BYTE  8'h00
`define SDMA_RST_EA    9'h000

`endif

//--- inc/sdma_pkg.sv
// Types of the sectored data memory addressing block.
// Assumes sdma_defs.svh sits on the include path.
`include "sdma_defs.svh"

package sdma_pkg;

  // Whole register state of the block
  typedef struct packed {
    logic [7:0] ptr0;
    logic [7:0] ptr1_lo;
    logic [7:0] ptr1_sec;
    logic [7:0] ptr2_lo;
    logic [7:0] ptr2_sec;
    logic [7:0] acc;
    logic [7:0] pc_low;
    logic [7:0] tbl_lo;
    logic [7:0] tbl_hi;
    logic [7:0] tbl_hbyte;
    logic [8:0] last_ea;
    logic [7:0] rdata;
    logic       jump;
    logic       dummy;
  } sdma_state_type;

endpackage

//--- verification/sdma_core_monitor.sv
// Checker for the sectored data memory addressing block.
// Sees only the top ports; bound to sdma_core below.
`timescale 1ns/1ps
`default_nettype none

module sdma_core_monitor (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [8:0] i_addr,
  input wire logic       i_ext,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_bit_set,
  input wire logic       i_bit_clr,
  input wire logic       i_wr_from_acc,
  input wire logic       i_alu_valid,
  input wire logic [7:0] i_alu_result,
  input wire logic       i_tbl_done,
  input wire logic [7:0] i_tbl_high,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_pc_low,
  input wire logic       o_pc_jump,
  input wire logic       o_dummy_cycle,
  input wire logic [15:0] o_table_addr,
  input wire logic [7:0] o_table_high
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Plain bus write to the counter low byte
  sequence pc_wr_s;
    i_wr && !i_wr_from_acc && !i_ext && i_addr[7:0] == 8'h06;
  endsequence
  // Access checks
  unused_zero_a: assert property (i_rd && !i_ext && i_addr[7:0] inside {[8'h0e:8'h7f]} |=> o_rdata == 8'h00) else $error("unused spot read not zero");
  sec1_special_a: assert property (i_rd && i_ext && i_addr[8:7] == 2'b10 |=> o_rdata == 8'h00) else $error("sector 1 special read not zero");
  pc_jump_a: assert property (pc_wr_s |=> o_pc_jump && o_dummy_cycle && o_pc_low == $past(i_wdata)) else $error("counter write gave no jump");
  jump_cause_a: assert property (o_pc_jump |-> $past(i_wr || i_bit_set || i_bit_clr) && o_dummy_cycle ##1 ($past(i_wr || i_bit_set || i_bit_clr) || !o_pc_jump)) else $error("stray or long jump pulse");
  table_latch_a: assert property (i_tbl_done && !i_wr && !i_bit_set && !i_bit_clr |=> o_table_high == $past(i_tbl_high)) else $error("table high byte not latched");
  table_ptr_a: assert property (i_wr && !i_wr_from_acc && !i_ext && i_addr[7:0] == 8'h07 |=> o_table_addr[7:0] == $past(i_wdata)) else $error("table low pointer not written");
  acc_alu_a: assert property (i_alu_valid && !i_wr && !i_rd && !i_bit_set && !i_bit_clr |=> o_acc == $past(i_alu_result)) else $error("alu result not in accumulator");
  acc_hold_a: assert property (!(i_alu_valid || i_wr || i_rd || i_bit_set || i_bit_clr) |=> $stable(o_acc)) else $error("accumulator changed unasked");
endmodule

bind sdma_core sdma_core_monitor u_mon (.*);

`default_nettype wire

//--- verification/sdma_fetch_model.sv
// Core-side table fetch model: returns a program word's high byte.
// Assumes one clock; the bench pulses i_go for one cycle.
`timescale 1ns/1ps
`default_nettype none

module sdma_fetch_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic        i_slow,
  input  wire logic [15:0] i_addr,
  output logic             o_done,
  output logic       [7:0] o_high
);
  // Answer after 1 or 4 cycles; bus shows inverse value when idle
  initial begin
    o_done = 1'b0;
    o_high = 8'h00;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        repeat (i_slow ? 3 : 0) @(posedge i_clk);
        o_done <= 1'b1;
        o_high <= i_addr[15:8] ^ i_addr[7:0];
        @(posedge i_clk);
        o_done <= 1'b0;
        o_high <= ~o_high;
      end
    end
  end
endmodule

`default_nettype wire

//--- verification/sectored_data_memory_addressing_bench.sv
// Self-checking bench for the sectored data memory addressing block.
// Assumes sdma_core, its checker and the fetch model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module sectored_data_memory_addressing_bench;
  localparam logic [5:0] W = 6'h01, R = 6'h02, S = 6'h04, C = 6'h08, WA = 6'h11, RA = 6'h22;
  logic i_clk = 0, i_rst = 1, i_ext = 0, i_wr = 0, i_rd = 0, i_bit_set = 0, i_bit_clr = 0;
  logic i_wr_from_acc = 0, i_rd_to_acc = 0, i_alu_valid = 0, i_pc_load = 0, go = 0, slow = 0;
  logic rd_d = 0, td_d = 0, i_tbl_done, o_pc_jump, o_dummy_cycle;
  logic [8:0] i_addr = 0;
  logic [2:0] i_bit_sel = 0;
  logic [7:0] i_wdata = 0, i_alu_result = 0, i_pc_low = 0, i_tbl_high, o_rdata, o_acc;
  logic [7:0] o_pc_low, o_table_high, d, h, l;
  logic [15:0] o_table_addr;
  logic [7:0] q[$];
  int err_count = 0, checks = 0, seed = 4734, n;

  sdma_core u_dut (.*);
  sdma_fetch_model u_core (.i_clk(i_clk), .i_go(go), .i_slow(slow), .i_addr(o_table_addr),
    .o_done(i_tbl_done), .o_high(i_tbl_high));

  always #2 i_clk = ~i_clk;

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (e !== g) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task print_verdict;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One bus cycle; a read notes its expected data
  task bus(input logic [5:0] op, input logic [8:0] a, input logic [7:0] dv, input logic [7:0] e);
    {i_rd_to_acc, i_wr_from_acc, i_bit_clr, i_bit_set, i_rd, i_wr} <= op;
    i_addr <= a;
    i_ext <= a[8];
    i_wdata <= dv;
    i_bit_sel <= dv[2:0];
    if (op[1]) q.push_back(e);
    @(posedge i_clk);
  endtask

  // Watch results and compare with the oldest note
  always @(posedge i_clk) begin
    rd_d <= i_rd && !i_rst;
    td_d <= i_tbl_done && !i_rst;
  end
  always @(negedge i_clk) begin
    if (rd_d) chk("rdata", q.pop_front(), o_rdata);
    if (td_d) chk("table_high", q.pop_front(), o_table_high);
  end

  // Cut a hang short
  initial begin
    repeat (2000) @(posedge i_clk);
    err_count++;
    print_verdict;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 0;
    @(posedge i_clk);
    for (int k = 1; k < 13; k++) if (k % 8 != 2) bus(R, 9'(k), 0, 0);
    for (int k = 1; k < 13; k++) if (k % 8 != 2) begin
      d = 8'($random(seed));
      bus(W, 9'(k), d, 0);
      bus(R, 9'(k), 0, d);
    end
    d = 8'($random(seed));
    h = 8'($random(seed));
    l = 8'($random(seed));
    bus(W, 9'h090, d, 0);
    bus(W, 9'h190, h, 0);
    bus(R, 9'h090, 0, d);
    bus(R, 9'h190, 0, h);
    bus(W, 9'h004, 8'h03, 0);
    bus(W, 9'h003, 8'h90, 0);
    bus(R, 9'h002, 0, h);
    bus(W, 9'h00c, 8'h00, 0);
    bus(W, 9'h00b, 8'h90, 0);
    bus(W, 9'h00a, l, 0);
    bus(R, 9'h090, 0, l);
    bus(W, 9'h001, 8'h90, 0);
    bus(R, 9'h000, 0, l);
    bus(W, 9'h001, 8'h02, 0);
    bus(W, 9'h000, 8'h5a, 0);
    bus(R, 9'h000, 0, 0);
    bus(R, 9'h190, 0, h);
    bus(W, 9'h020, d, 0);
    bus(R, 9'h020, 0, 0);
    bus(W, 9'h120, d, 0);
    bus(R, 9'h120, 0, 0);
    bus(W, 9'h00d, 8'hff, 0);
    bus(R, 9'h00d, 0, 8'h0d);
    bus(W, 9'h1a0, 0, 0);
    bus(S, 9'h1a0, 5, 0);
    bus(S, 9'h1a0, 0, 0);
    bus(C, 9'h1a0, 5, 0);
    bus(R, 9'h1a0, 0, 8'h01);
    bus(W, 9'h003, 8'hff, 0);
    bus(W, 9'h003, 8'h00, 0);
    bus(R, 9'h004, 0, 8'h03);
    bus(RA, 9'h090, 0, l);
    bus(WA, 9'h1b0, 0, 0);
    bus(R, 9'h1b0, 0, l);
    i_alu_valid <= 1;
    i_alu_result <= d;
    i_pc_load <= 1;
    i_pc_low <= h;
    bus(0, 0, 0, 0);
    i_alu_valid <= 0;
    i_pc_load <= 0;
    bus(R, 9'h005, 0, d);
    bus(R, 9'h006, 0, h);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      d = 8'($random(seed));
      h = 8'($random(seed));
      bus(W, 9'h007, d, 0);
      bus(W, 9'h009, h, 0);
      go <= 1;
      q.push_back(d ^ h);
      bus(0, 0, 0, 0);
      go <= 0;
      n = 0;
      while (!i_tbl_done && n < 9) begin
        @(negedge i_clk);
        n++;
      end
      if (n == 9) begin
        err_count++;
        $display("Error table_done expected 1 seen 0");
      end
      @(posedge i_clk);
    end
    bus(0, 0, 0, 0);
    bus(0, 0, 0, 0);
    if (q.size() != 0) begin
      err_count++;
      $display("Error pending_notes expected 0 seen %0d", q.size());
    end
    print_verdict;
  end
endmodule

`default_nettype wire
